// File: logic/canopen_comm_object_bank.sv
// communication object bank: device identity, error log, guarding and store
`timescale 1ns/1ps
// Function
// - device type is read-only: upper 16 bits extra info, lower 16 bits profile
// - read-only 8-bit error class register shows most recent error classes
// - history: subindex 0 count, 1 newest code, 2 the code before
// - writing zero to the count empties the whole history
// - writable 32-bit sync identifier, reset value 0x80
// - name and version strings are constant, read only by segmented transfer
// - writable 16-bit guard time in ms, reset zero, zero disables guarding
// - life time equals life multiplier times guard time
// - life multiplier zero, its reset value, disables guarding
// - writing the save signature to store subindex 1 to 3 starts a save unless flash is busy
// - reading store subindex 1 to 3 returns capability, reset read value one
// - store sub 1 all, sub 2 communication, sub 3 application parameters
// - store subindex 0 is read-only and reads nine
// - flash wears out; frequent saves are left to the master to avoid
module canopen_comm_object_bank (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// object access
	input wire comm_object_pkg::obj_req_t req_in,
	output comm_object_pkg::obj_ans_t ans_out,
	// error events from the drive
	input wire comm_object_pkg::err_event_t err_in,
	// node guarding
	input wire logic guard_request_in,
	output logic guard_error_out,
	output logic guard_enabled_out,
	// flash save
	output logic save_start_out,
	output comm_object_pkg::save_scope_t save_scope_out,
	input wire logic save_busy_in,
	// settings for the rest of the drive
	output logic [31:0] sync_id_out
);
	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// request decode
	wire req_valid = req_in.valid;
	wire req_write = req_in.write;
	wire [15:0] req_idx = req_in.index;
	wire [7:0] req_sub = req_in.subindex;
	wire sub0 = (req_sub == comm_object_pkg::SUB_COUNT);
	wire hit_type = (req_idx == comm_object_pkg::IDX_DEVICE_TYPE) && sub0;
	wire hit_class = (req_idx == comm_object_pkg::IDX_ERROR_CLASS) && sub0;
	wire hit_hist = (req_idx == comm_object_pkg::IDX_ERROR_HIST) &&
		(req_sub <= comm_object_pkg::SUB_SECOND);
	wire hit_sync = (req_idx == comm_object_pkg::IDX_SYNC_ID) && sub0;
	wire hit_name = (req_idx == comm_object_pkg::IDX_DEV_NAME) && sub0;
	wire hit_hw = (req_idx == comm_object_pkg::IDX_HW_VER) && sub0;
	wire hit_sw = (req_idx == comm_object_pkg::IDX_SW_VER) && sub0;
	wire hit_guard = (req_idx == comm_object_pkg::IDX_GUARD_MS) && sub0;
	wire hit_life = (req_idx == comm_object_pkg::IDX_LIFE_MULT) && sub0;
	wire hit_store = (req_idx == comm_object_pkg::IDX_STORE) &&
		(req_sub <= comm_object_pkg::SUB_THIRD);
	wire hit_text = hit_name || hit_hw || hit_sw;
	wire hit_any = hit_type || hit_class || hit_hist || hit_sync || hit_text ||
		hit_guard || hit_life || hit_store;
	// read-only entries: type, class, history codes, strings, store count
	wire hit_ro = hit_type || hit_class || (hit_hist && !sub0) || hit_text ||
		(hit_store && sub0);
	wire text_expedited = hit_text && !req_in.segmented;
	wire wr_ok = req_valid && req_write && hit_any && !hit_ro;
	wire wr_count = wr_ok && hit_hist;
	wire wr_sync = wr_ok && hit_sync;
	wire wr_guard = wr_ok && hit_guard;
	wire wr_life = wr_ok && hit_life;
	wire wr_store = wr_ok && hit_store;

	// text lookup, one cycle of latency matched by the answer stage below
	logic [7:0] text_byte;
	wire [1:0] text_sel = hit_name ? 2'h0 : (hit_hw ? 2'h1 : 2'h2);
	wire [2:0] text_pos = req_in.seg_pos;
	text_rom u_text (
		.clk_in(clk_in),
		.sel_in(text_sel),
		.pos_in(text_pos),
		.byte_out(text_byte)
	);

	// writable objects
	logic [31:0] sync_id_q;
	logic [31:0] sync_id_d;
	logic [15:0] guard_ms_q;
	logic [15:0] guard_ms_d;
	logic [7:0] life_mult_q;
	logic [7:0] life_mult_d;
	assign sync_id_d = wr_sync ? req_in.wdata : sync_id_q;
	assign guard_ms_d = wr_guard ? req_in.wdata[15:0] : guard_ms_q;
	assign life_mult_d = wr_life ? req_in.wdata[7:0] : life_mult_q;
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			sync_id_q <= comm_object_pkg::SYNC_ID_RESET;
		end else begin
			sync_id_q <= sync_id_d;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			guard_ms_q <= comm_object_pkg::GUARD_MS_RESET;
		end else begin
			guard_ms_q <= guard_ms_d;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			life_mult_q <= comm_object_pkg::LIFE_MULT_RESET;
		end else begin
			life_mult_q <= life_mult_d;
		end
	end

	// error class flags and two-entry history
	logic [7:0] err_class_q;
	logic [7:0] err_class_d;
	logic [7:0] hist_count_q;
	logic [7:0] hist_count_d;
	logic [31:0] hist_new_q;
	logic [31:0] hist_new_d;
	logic [31:0] hist_old_q;
	logic [31:0] hist_old_d;
	// a new error in the clearing cycle survives as the only entry
	wire hist_clear = wr_count && (req_in.wdata[7:0] == 8'h00);
	wire [7:0] count_sat = (hist_count_q >= 8'(comm_object_pkg::HIST_DEPTH)) ?
		8'(comm_object_pkg::HIST_DEPTH) : 8'(hist_count_q + 8'h01);
	assign err_class_d = err_in.valid ? err_in.classes : err_class_q;
	assign hist_count_d = err_in.valid ? (hist_clear ? 8'h01 : count_sat) :
		(hist_clear ? 8'h00 : hist_count_q);
	assign hist_new_d = err_in.valid ? err_in.code : (hist_clear ? 32'h0000_0000 : hist_new_q);
	assign hist_old_d = err_in.valid ? (hist_clear ? 32'h0000_0000 : hist_new_q) :
		(hist_clear ? 32'h0000_0000 : hist_old_q);
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			err_class_q <= 8'h00;
		end else begin
			err_class_q <= err_class_d;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			hist_count_q <= 8'h00;
		end else begin
			hist_count_q <= hist_count_d;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			hist_new_q <= 32'h0000_0000;
		end else begin
			hist_new_q <= hist_new_d;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			hist_old_q <= 32'h0000_0000;
		end else begin
			hist_old_q <= hist_old_d;
		end
	end

	// store parameters: only the exact signature starts a save
	wire sig_match = (req_in.wdata == comm_object_pkg::SAVE_SIGNATURE);
	wire store_go = wr_store && !sub0 && sig_match && !save_busy_in;
	wire [1:0] scope_d = (req_sub == comm_object_pkg::SUB_FIRST) ? 2'h1 :
		(req_sub == comm_object_pkg::SUB_SECOND) ? 2'h2 : 2'h3;
	logic save_start_q;
	logic [1:0] save_scope_q;
	// a save requested while flash is busy is dropped, sparing wear
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			save_start_q <= 1'b0;
		end else begin
			save_start_q <= store_go;
		end
	end

	// the scope holds after the strobe so the flash side may read it late
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			save_scope_q <= 2'h0;
		end else if (store_go) begin
			save_scope_q <= scope_d;
		end
	end

	// node guarding: life time in ms counted on a 1 ms tick
	wire guard_on = (guard_ms_q != 16'h0000) && (life_mult_q != 8'h00);
	wire [23:0] life_ms = 24'(guard_ms_q) * 24'(life_mult_q);
	logic [14:0] tick_q;
	logic [23:0] elapsed_q;
	logic guard_err_q;
	wire ms_tick = (tick_q == comm_object_pkg::MS_TICK_LAST);
	wire restart = !guard_on || guard_request_in;
	wire expired = guard_on && (elapsed_q >= life_ms) && !guard_request_in;
	logic [14:0] tick_d;
	logic [23:0] elapsed_d;
	logic guard_err_d;
	// elapsed stops at the life time so a long silence cannot wrap it back below
	assign tick_d = (restart || ms_tick) ? 15'h0000 : 15'(tick_q + 15'h0001);
	assign elapsed_d = restart ? 24'h000000 :
		((ms_tick && !expired) ? 24'(elapsed_q + 24'h000001) : elapsed_q);
	// a guard request wins over the expiry in the same cycle
	assign guard_err_d = restart ? 1'b0 : (expired ? 1'b1 : guard_err_q);
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			tick_q <= 15'h0000;
		end else begin
			tick_q <= tick_d;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			elapsed_q <= 24'h000000;
		end else begin
			elapsed_q <= elapsed_d;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			guard_err_q <= 1'b0;
		end else begin
			guard_err_q <= guard_err_d;
		end
	end

	// answer stage: one cycle after the request
	logic [31:0] rd_word;
	wire [31:0] hist_word = (req_sub == comm_object_pkg::SUB_COUNT) ? {24'h000000, hist_count_q} :
		(req_sub == comm_object_pkg::SUB_FIRST) ? hist_new_q : hist_old_q;
	wire [31:0] store_word = sub0 ? {24'h000000, comm_object_pkg::STORE_ENTRIES} :
		comm_object_pkg::STORE_CAPABILITY;
	assign rd_word = hit_type ? {comm_object_pkg::TYPE_ADDITIONAL,
		comm_object_pkg::TYPE_PROFILE} :
		hit_class ? {24'h000000, err_class_q} :
		hit_hist ? hist_word :
		hit_sync ? sync_id_q :
		hit_guard ? {16'h0000, guard_ms_q} :
		hit_life ? {24'h000000, life_mult_q} :
		hit_store ? store_word : 32'h0000_0000;
	wire [1:0] code_d = !hit_any ? comm_object_pkg::ANS_NO_OBJECT :
		text_expedited ? comm_object_pkg::ANS_NEED_SEGMENTED :
		(req_write && hit_ro) ? comm_object_pkg::ANS_READ_ONLY : comm_object_pkg::ANS_OK;
	logic ans_valid_q;
	logic [1:0] ans_code_q;
	logic [31:0] ans_word_q;
	logic ans_text_q;
	wire [31:0] ans_word_d = req_write ? 32'h0000_0000 : rd_word;
	wire ans_text_d = hit_text && !req_write && !text_expedited;
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ans_valid_q <= 1'b0;
		end else begin
			ans_valid_q <= req_valid;
		end
	end

	// code and word hold until the next answer, a text byte does not; valid alone marks it
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ans_code_q <= comm_object_pkg::ANS_OK;
			ans_word_q <= 32'h0000_0000;
			ans_text_q <= 1'b0;
		end else if (req_valid) begin
			ans_code_q <= code_d;
			ans_word_q <= ans_word_d;
			ans_text_q <= ans_text_d;
		end
	end

	// text byte joins from the rom register; a second register would cost a cycle
	wire [31:0] ans_rdata = ans_text_q ? {24'h000000, text_byte} : ans_word_q;
	assign ans_out = '{valid: ans_valid_q, code: ans_code_q, rdata: ans_rdata};
	assign guard_error_out = guard_err_q;
	// registered copy of the enable so the output comes from a flip-flop
	logic guard_en_q;
	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			guard_en_q <= 1'b0;
		end else begin
			guard_en_q <= guard_on;
		end
	end
	assign guard_enabled_out = guard_en_q;
	assign save_start_out = save_start_q;
	assign save_scope_out = comm_object_pkg::save_scope_t'(save_scope_q);
	assign sync_id_out = sync_id_q;
endmodule

// File: logic/comm_object_pkg.sv
// constants and carriers for the communication object bank
package comm_object_pkg;
	// object indices
	localparam logic [15:0] IDX_DEVICE_TYPE = 16'h1000;
	localparam logic [15:0] IDX_ERROR_CLASS = 16'h1001;
	localparam logic [15:0] IDX_ERROR_HIST = 16'h1003;
	localparam logic [15:0] IDX_SYNC_ID = 16'h1005;
	localparam logic [15:0] IDX_DEV_NAME = 16'h1008;
	localparam logic [15:0] IDX_HW_VER = 16'h1009;
	localparam logic [15:0] IDX_SW_VER = 16'h100A;
	localparam logic [15:0] IDX_GUARD_MS = 16'h100C;
	localparam logic [15:0] IDX_LIFE_MULT = 16'h100D;
	localparam logic [15:0] IDX_STORE = 16'h1010;
	// subindices
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_FIRST = 8'h01;
	localparam logic [7:0] SUB_SECOND = 8'h02;
	localparam logic [7:0] SUB_THIRD = 8'h03;
	// device type fields; value is arbitrary, not any real part code
	localparam logic [15:0] TYPE_ADDITIONAL = 16'h0001;
	localparam logic [15:0] TYPE_PROFILE = 16'h0001;
	// reset values and fixed constants
	localparam logic [31:0] SYNC_ID_RESET = 32'h0000_0080;
	localparam logic [15:0] GUARD_MS_RESET = 16'h0000;
	localparam logic [7:0] LIFE_MULT_RESET = 8'h00;
	localparam logic [7:0] STORE_ENTRIES = 8'h09;
	localparam logic [31:0] STORE_CAPABILITY = 32'h0000_0001;
	localparam logic [31:0] SAVE_SIGNATURE = 32'h6576_6173;
	localparam logic [1:0] HIST_DEPTH = 2'h2;
	// text strings
	localparam int TEXT_LEN = 8;
	localparam logic [2:0] TEXT_LAST = 3'h7;
	// eight characters each, first character in the top byte; contents are arbitrary
	localparam logic [63:0] TEXT_NAME = 64'h5345_5256_4F44_5256;
	localparam logic [63:0] TEXT_HW = 64'h4857_2031_2E30_2020;
	localparam logic [63:0] TEXT_SW = 64'h5357_2031_2E30_2020;
	// timing: one millisecond at 20 MHz
	localparam int CLK_HZ = 20_000_000;
	localparam int MS_PER_S = 1000;
	localparam int TICKS_PER_MS = CLK_HZ / MS_PER_S;
	localparam logic [14:0] MS_TICK_LAST = 15'(TICKS_PER_MS - 1);
	// answer codes: ok and abort answers
	localparam logic [1:0] ANS_OK = 2'h0;
	localparam logic [1:0] ANS_NO_OBJECT = 2'h1;
	localparam logic [1:0] ANS_READ_ONLY = 2'h2;
	localparam logic [1:0] ANS_NEED_SEGMENTED = 2'h3;
	// which parameter set a save covers
	typedef enum logic [1:0] {
		SAVE_NONE,
		SAVE_ALL,
		SAVE_COMM,
		SAVE_APP
	} save_scope_t;
	// object access request from the sdo server
	typedef struct packed {
		logic valid;
		logic write;
		logic segmented;
		logic [15:0] index;
		logic [7:0] subindex;
		logic [2:0] seg_pos;
		logic [31:0] wdata;
	} obj_req_t;
	// answer to the sdo server
	typedef struct packed {
		logic valid;
		logic [1:0] code;
		logic [31:0] rdata;
	} obj_ans_t;
	// event record of a new error
	typedef struct packed {
		logic valid;
		logic [7:0] classes;
		logic [31:0] code;
	} err_event_t;
endpackage

// File: logic/text_rom.sv
// constant text strings read a byte at a time from a register
`timescale 1ns/1ps
module text_rom (
	// clock
	input wire logic clk_in,
	// lookup
	input wire logic [1:0] sel_in,
	input wire logic [2:0] pos_in,
	output logic [7:0] byte_out
);
	logic [7:0] byte_q;
	logic [7:0] byte_d;
	// three strings of eight characters: name, hardware, software
	wire [63:0] text_sel = (sel_in == 2'h0) ? comm_object_pkg::TEXT_NAME :
		((sel_in == 2'h1) ? comm_object_pkg::TEXT_HW : comm_object_pkg::TEXT_SW);
	wire [5:0] bit_base = 6'(6'h38 - {pos_in, 3'h0});
	assign byte_d = text_sel[bit_base +: 8];
	always_ff @(posedge clk_in) begin
		byte_q <= byte_d;
	end
	assign byte_out = byte_q;
endmodule

// File: tb/canopen_comm_object_bank_monitor.sv
// assertion checker on the object bank ports
`timescale 1ns/1ps
module canopen_comm_object_bank_monitor (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// object access
	input wire comm_object_pkg::obj_req_t req_in,
	input wire comm_object_pkg::obj_ans_t ans_out,
	// events, guarding, save
	input wire comm_object_pkg::err_event_t err_in,
	input wire logic guard_request_in,
	input wire logic guard_error_out,
	input wire logic guard_enabled_out,
	input wire logic save_start_out,
	input wire comm_object_pkg::save_scope_t save_scope_out,
	input wire logic save_busy_in,
	input wire logic [31:0] sync_id_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	wire logic rd = req_in.valid && !req_in.write;
	wire logic wr = req_in.valid && req_in.write;
	wire logic [15:0] ix = req_in.index;
	wire logic [7:0] sb = req_in.subindex;
	wire logic sig = req_in.wdata == 32'h6576_6173;
	property p_type;
		rd && ix == 16'h1000 && sb == 8'h00 |=> ans_out.valid && ans_out.code == 2'h0
			&& ans_out.rdata == {comm_object_pkg::TYPE_ADDITIONAL, comm_object_pkg::TYPE_PROFILE};
	endproperty
	a_type: assert property (p_type) else $error("device type answer wrong");
	property p_ro;
		wr && (ix == 16'h1000 || ix == 16'h1001) && sb == 8'h00 |=> ans_out.code == 2'h2;
	endproperty
	a_ro: assert property (p_ro) else $error("read-only write not refused");
	property p_text;
		rd && !req_in.segmented && ix inside {16'h1008, 16'h1009, 16'h100A} |=> ans_out.code == 2'h3;
	endproperty
	a_text: assert property (p_text) else $error("expedited string read allowed");
	property p_store_cnt;
		rd && ix == 16'h1010 && sb == 8'h00 |=> ans_out.rdata[7:0] == 8'h09;
	endproperty
	a_store_cnt: assert property (p_store_cnt) else $error("store entry count wrong");
	property p_save;
		wr && sig && ix == 16'h1010 && sb inside {8'h01, 8'h02, 8'h03} && !save_busy_in
			|=> save_start_out && save_scope_out == $past(sb[1:0]);
	endproperty
	a_save: assert property (p_save) else $error("save not started with its scope");
	property p_no_save;
		save_start_out |-> $past(wr && sig && ix == 16'h1010);
	endproperty
	a_no_save: assert property (p_no_save) else $error("save started without signature");
	property p_sync_rst;
		$rose(rst_b_in) |-> sync_id_out == 32'h80;
	endproperty
	a_sync_rst: assert property (p_sync_rst) else $error("sync identifier reset wrong");
	// registered flags may lag the disable by a cycle, hence three cycles
	property p_guard_off;
		!guard_enabled_out [*3] |-> !guard_error_out;
	endproperty
	a_guard_off: assert property (p_guard_off) else $error("guard error while disabled");
	c_save: cover property (save_start_out);
	c_guard: cover property (guard_error_out);
	c_seg: cover property (ans_out.valid && ans_out.code == 2'h3);
endmodule
bind canopen_comm_object_bank canopen_comm_object_bank_monitor i_mon (.clk_in, .rst_b_in,
	.req_in, .ans_out, .err_in, .guard_request_in, .guard_error_out, .guard_enabled_out,
	.save_start_out, .save_scope_out, .save_busy_in, .sync_id_out);

// File: tb/sdo_master_model.sv
// network master model issuing one object access per call
`timescale 1ns/1ps
module sdo_master_model (
	// clock
	input wire logic clk_in,
	// object access
	output comm_object_pkg::obj_req_t req_out,
	input wire comm_object_pkg::obj_ans_t ans_in
);
	initial req_out = '0;
	task automatic access(input logic w, input logic seg, input logic [15:0] idx,
		input logic [7:0] sub, input logic [2:0] pos, input logic [31:0] wd,
		output comm_object_pkg::obj_ans_t ans);
		@(negedge clk_in);
		req_out = '{1'b1, w, seg, idx, sub, pos, wd};
		@(negedge clk_in);
		ans = ans_in;
		// released fields go inverted so a stale word never looks fresh
		req_out = ~req_out;
	endtask
endmodule

// File: tb/canopen_comm_object_bank_test.sv
// self-checking bench for the communication object bank
`timescale 1ns/1ps
module canopen_comm_object_bank_test;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	comm_object_pkg::obj_req_t req;
	comm_object_pkg::obj_ans_t ans;
	comm_object_pkg::obj_ans_t a;
	logic [63:0] txt;
	comm_object_pkg::err_event_t err_in = '0;
	logic guard_request_in = 1'b0;
	logic save_busy_in = 1'b0;
	logic guard_error_out;
	logic guard_enabled_out;
	logic save_start_out;
	comm_object_pkg::save_scope_t save_scope_out;
	logic [31:0] sync_id_out;
	int err_total = 0;
	int total_checks = 0;
	always #25 clk_in = ~clk_in;
	canopen_comm_object_bank i_dut (.clk_in, .rst_b_in, .req_in(req), .ans_out(ans), .err_in,
		.guard_request_in, .guard_error_out, .guard_enabled_out, .save_start_out,
		.save_scope_out, .save_busy_in, .sync_id_out);
	sdo_master_model i_master (.clk_in, .req_out(req), .ans_in(ans));
	task automatic chk(input logic [34:0] got, input logic [34:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// data is compared only on plain reads that succeed
	task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, input logic [1:0] code, input logic [31:0] exp);
		i_master.access(w, 1'b0, idx, sub, 3'h0, wd, a);
		chk({a.valid, a.code}, {1'b1, code});
		if (!w && code == 2'h0) chk(a.rdata, exp);
	endtask
	task automatic evt(input logic [7:0] cls, input logic [31:0] code);
		@(negedge clk_in);
		err_in = '{1'b1, cls, code};
		@(negedge clk_in);
		err_in = '0;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#4_000_000;
		err_total++;
		close_out();
	end
	initial begin
		repeat (3) @(negedge clk_in);
		rst_b_in = 1'b1;
		repeat (3) @(negedge clk_in);
		acc(1'b0, 16'h1000, 8'h00, '0, 2'h0, {comm_object_pkg::TYPE_ADDITIONAL,
			comm_object_pkg::TYPE_PROFILE});
		acc(1'b1, 16'h1000, 8'h00, 32'h5, 2'h2, '0);
		acc(1'b0, 16'h1005, 8'h00, '0, 2'h0, 32'h80);
		acc(1'b0, 16'h100C, 8'h00, '0, 2'h0, '0);
		acc(1'b0, 16'h100D, 8'h00, '0, 2'h0, '0);
		acc(1'b0, 16'h1010, 8'h00, '0, 2'h0, 32'h9);
		acc(1'b1, 16'h1010, 8'h00, 32'h5, 2'h2, '0);
		acc(1'b0, 16'h2000, 8'h00, '0, 2'h1, '0);
		$display("test reset values done");
		evt(8'h04, 32'h1111);
		acc(1'b0, 16'h1001, 8'h00, '0, 2'h0, 32'h04);
		acc(1'b1, 16'h1001, 8'h00, '0, 2'h2, '0);
		evt(8'h10, 32'h2222);
		acc(1'b0, 16'h1001, 8'h00, '0, 2'h0, 32'h10);
		acc(1'b0, 16'h1003, 8'h00, '0, 2'h0, 32'h2);
		acc(1'b0, 16'h1003, 8'h01, '0, 2'h0, 32'h2222);
		acc(1'b0, 16'h1003, 8'h02, '0, 2'h0, 32'h1111);
		acc(1'b1, 16'h1003, 8'h00, '0, 2'h0, '0);
		acc(1'b0, 16'h1003, 8'h00, '0, 2'h0, '0);
		acc(1'b1, 16'h1005, 8'h00, 32'h181, 2'h0, '0);
		acc(1'b0, 16'h1005, 8'h00, '0, 2'h0, 32'h181);
		chk(sync_id_out, 32'h181);
		$display("test errors and sync done");
		for (int t = 0; t < 3; t++) begin
			txt = (t == 0) ? comm_object_pkg::TEXT_NAME :
				((t == 1) ? comm_object_pkg::TEXT_HW : comm_object_pkg::TEXT_SW);
			acc(1'b0, 16'h1008 + t[15:0], 8'h00, '0, 2'h3, '0);
			for (int p = 0; p < 8; p++) begin
				i_master.access(1'b0, 1'b1, 16'h1008 + t[15:0], 8'h00, p[2:0], '0, a);
				chk({a.valid, a.code, a.rdata}, {3'b100, 24'h000000, txt[63 - 8 * p -: 8]});
			end
		end
		$display("test strings done");
		for (int s = 1; s < 4; s++) begin
			acc(1'b1, 16'h1010, s[7:0], 32'h6576_6173, 2'h0, '0);
			chk({save_start_out, 2'(save_scope_out)}, {1'b1, s[1:0]});
			acc(1'b0, 16'h1010, s[7:0], '0, 2'h0, 32'h1);
		end
		acc(1'b1, 16'h1010, 8'h01, 32'h6576_6174, 2'h0, '0);
		chk(save_start_out, 1'b0);
		save_busy_in = 1'b1;
		acc(1'b1, 16'h1010, 8'h02, 32'h6576_6173, 2'h0, '0);
		chk(save_start_out, 1'b0);
		save_busy_in = 1'b0;
		$display("test store done");
		acc(1'b1, 16'h100C, 8'h00, 32'h1, 2'h0, '0);
		acc(1'b1, 16'h100D, 8'h00, 32'h2, 2'h0, '0);
		guard_request_in = 1'b1;
		@(negedge clk_in);
		guard_request_in = 1'b0;
		@(negedge clk_in);
		chk(guard_enabled_out, 1'b1);
		repeat (38000) @(negedge clk_in);
		chk(guard_error_out, 1'b0);
		repeat (6000) @(negedge clk_in);
		chk(guard_error_out, 1'b1);
		guard_request_in = 1'b1;
		@(negedge clk_in);
		guard_request_in = 1'b0;
		repeat (2) @(negedge clk_in);
		chk(guard_error_out, 1'b0);
		acc(1'b1, 16'h100D, 8'h00, '0, 2'h0, '0);
		repeat (3) @(negedge clk_in);
		chk({guard_enabled_out, guard_error_out}, 2'b00);
		acc(1'b1, 16'h100D, 8'h00, 32'h2, 2'h0, '0);
		acc(1'b1, 16'h100C, 8'h00, '0, 2'h0, '0);
		repeat (3) @(negedge clk_in);
		chk(guard_enabled_out, 1'b0);
		$display("test guarding done");
		rst_b_in = 1'b0;
		repeat (3) @(negedge clk_in);
		chk({sync_id_out, save_start_out, guard_enabled_out}, {32'h80, 2'b00});
		rst_b_in = 1'b1;
		repeat (3) @(negedge clk_in);
		acc(1'b0, 16'h1005, 8'h00, '0, 2'h0, 32'h80);
		acc(1'b0, 16'h100D, 8'h00, '0, 2'h0, '0);
		$display("test mid-run reset done");
		close_out();
	end
endmodule
